// file: verilog/dpdc_regs.svh
// dpdc_regs.svh: timing counts, refresh pacing and port select codes of the two-port dram controller.
// assumes: included by bare name; every timeline count is in half master-clock cycles,
// one half cycle being one period of the 200 MHz clock.
`ifndef DPDC_REGS_SVH
`define DPDC_REGS_SVH

// ----------------------------------------------------------------
// access and refresh timeline, steps after the cycle starts
// ----------------------------------------------------------------
`define DPDC_T_RAS_ON   4'h1
`define DPDC_T_COL_STD  4'h3
`define DPDC_T_COL_RED  4'h2
`define DPDC_T_COLUMN_STROBE_ENABLE_N    4'h4
`define DPDC_T_RAS_OFF  4'h9
`define DPDC_T_REF_END  4'hF

// ----------------------------------------------------------------
// refresh pacing and port select codes, none being the reset value
// ----------------------------------------------------------------
`define DPDC_REF_DIV_LAST 6'h3F
`define DPDC_CHOSEN_NONE  2'h3
`define DPDC_CHOSEN_P1    2'h2
`define DPDC_CHOSEN_P2    2'h1

`endif

// file: verilog/dpdc_pkg.sv
// dpdc_pkg: types shared by the two-port dram controller modules.
// assumes: compiled before every other design file.
`default_nettype none

package dpdc_pkg;

    // ----------------------------------------------------------------
    // sequencer states, gray along idle-access-hold and idle-refresh
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        DPDC_IDLE    = 2'h0,
        DPDC_ACCESS  = 2'h1,
        DPDC_HOLD    = 2'h3,
        DPDC_REFRESH = 2'h2
    } dpdc_state_t;

endpackage : dpdc_pkg

`default_nettype wire

// file: verilog/dpdc_core_if.sv
// dpdc_core_if: signals between the sequencer, the arbiter and the refresh timer.
// assumes: all three sit on the same clock.
`default_nettype none

interface dpdc_core_if;
    logic [1:0] chosenN;  // active-low port select, bit 0 is port 1
    logic askLive;        // synced request of the chosen port still active
    logic cycleDone;      // sequencer may let the chosen port go
    logic refPending;     // refresh waiting
    logic refDone;        // last step of a refresh cycle
    logic [8:0] refRow;   // row to refresh next

    modport arb (output chosenN, output askLive, input cycleDone);
    modport refr (output refPending, output refRow, input refDone);
    modport seq (input chosenN, input askLive, output cycleDone,
                 input refPending, input refRow, output refDone);
endinterface : dpdc_core_if

`default_nettype wire

// file: verilog/dpdc_arbiter.sv
// dpdc_arbiter: synchronises both requests and picks one port at a time.
// assumes: request pins are asynchronous; the sequencer reports when it may release.
`default_nettype none
`include "dpdc_regs.svh"

module dpdc_arbiter (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // request pins, active low
    input wire logic port1AskN,
    input wire logic port2AskN,
    // to the sequencer
    dpdc_core_if.arb core
);
    logic [1:0] askS1_r, askS1_nxt;   // first sync stage, active high
    logic [1:0] askS2_r, askS2_nxt;   // second sync stage
    logic phase_r, phase_nxt;         // 0 = rising half, 1 = falling half
    logic [1:0] chosenN_r, chosenN_nxt;

    // ----------------------------------------------------------------
    // sampling and selection
    // ----------------------------------------------------------------
    always_comb begin
        askS1_nxt = {~port2AskN, ~port1AskN};
        askS2_nxt = askS1_r;
        phase_nxt = ~phase_r;
        chosenN_nxt = chosenN_r;
        if (chosenN_r == `DPDC_CHOSEN_NONE) begin
            // alternate halves settle a tie without contention
            if (!phase_r && askS2_r[0]) begin
                chosenN_nxt = `DPDC_CHOSEN_P1;
            end else if (phase_r && askS2_r[1]) begin
                chosenN_nxt = `DPDC_CHOSEN_P2;
            end
        end else if (core.cycleDone && !core.askLive) begin
            chosenN_nxt = `DPDC_CHOSEN_NONE;
        end
        // while one port is chosen the other's synced request is never looked at
    end

    assign core.chosenN = chosenN_r;
    assign core.askLive = (!chosenN_r[0] && askS2_r[0]) || (!chosenN_r[1] && askS2_r[1]);

    always_ff @(posedge clock) begin
        if (rst) begin
            askS1_r <= 2'h0;
            askS2_r <= 2'h0;
            phase_r <= 1'b0;
            chosenN_r <= `DPDC_CHOSEN_NONE;
        end else begin
            askS1_r <= askS1_nxt;
            askS2_r <= askS2_nxt;
            phase_r <= phase_nxt;
            chosenN_r <= chosenN_nxt;
        end
    end
endmodule : dpdc_arbiter

`default_nettype wire

// file: verilog/dpdc_refresh.sv
// dpdc_refresh: divides the refresh clock by 64 and keeps the refresh row counter.
// assumes: refresh clock is asynchronous and far slower than the master clock.
`default_nettype none
`include "dpdc_regs.svh"

module dpdc_refresh (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // refresh pacing pin
    input wire logic refreshClock,
    // to the sequencer
    dpdc_core_if.refr core
);
    logic s1_r, s1_nxt;            // first sync stage
    logic s2_r, s2_nxt;            // second sync stage
    logic s3_r, s3_nxt;            // edge history
    logic [5:0] div_r, div_nxt;    // refresh clock divider
    logic pend_r, pend_nxt;        // refresh waiting
    logic [8:0] row_r, row_nxt;    // refresh row counter
    logic rise;

    // ----------------------------------------------------------------
    // divider, pending flag and row counter
    // ----------------------------------------------------------------
    always_comb begin
        s1_nxt = refreshClock;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
        rise = s2_r && !s3_r;
        // a clock parked high gives no rising edge, so no refresh
        div_nxt = rise ? div_r + 6'h1 : div_r;
        // set wins over the clear so no request is lost
        pend_nxt = (rise && div_r == `DPDC_REF_DIV_LAST) || (pend_r && !core.refDone);
        row_nxt = core.refDone ? row_r + 9'h1 : row_r;
    end

    assign core.refPending = pend_r;
    assign core.refRow = row_r;

    always_ff @(posedge clock) begin
        if (rst) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            div_r <= 6'h0;
            pend_r <= 1'b0;
            row_r <= 9'h0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
            div_r <= div_nxt;
            pend_r <= pend_nxt;
            row_r <= row_nxt;
        end
    end
endmodule : dpdc_refresh

`default_nettype wire

// file: verilog/dpdc_top.sv
// dpdc_top: two-port dram controller, arbitration, address mux and strobe timing.
// assumes: processors and refresh pacing are asynchronous to clock; the dram
// and any column strobe decode sit outside and read the registered outputs.
`default_nettype none
`include "dpdc_regs.svh"

module dpdc_top #(
    parameter bit LATCHED = 1'b1,       // keep an address latch
    parameter bit REDUCED_HOLD = 1'b0   // early column switch
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // processor side
    input wire logic port1AskN,
    input wire logic port2AskN,
    input wire logic [17:0] hostAddrIn,
    output logic port1ChosenN,
    output logic port2ChosenN,
    output logic cycleGrant,
    output logic transferAck,
    // refresh pacing
    input wire logic refreshClock,
    // dram side
    output logic [8:0] dramAddrOut,
    output logic rowStrobeN,
    output logic columnStrobeEnableN,
    output logic writeGate
);

    // ----------------------------------------------------------------
    // timing choices
    // ----------------------------------------------------------------
    // the master clock is modelled as two periods of clock, so every
    // half master cycle in the timeline is one edge of clock
    localparam logic [3:0] COL_STEP = REDUCED_HOLD ? `DPDC_T_COL_RED : `DPDC_T_COL_STD;

    // ----------------------------------------------------------------
    // internal wiring
    // ----------------------------------------------------------------
    dpdc_core_if core ();

    logic [17:0] addrS1_r, addrS1_nxt;   // address pins, first sync stage
    logic [17:0] addrS2_r, addrS2_nxt;   // address pins, second sync stage
    logic [17:0] latch_r, latch_nxt;     // captured address
    logic [17:0] srcAddr;                // address source for the mux
    dpdc_pkg::dpdc_state_t state_r, state_nxt;
    logic [3:0] step_r, step_nxt;        // half cycles into the cycle
    logic [3:0] stepInc;                 // step_r plus one
    logic grant_r, grant_nxt;
    logic ras_r, ras_nxt;                // active low row strobe
    logic column_strobe_enable_n_r, column_strobe_enable_n_nxt;            // active low column strobe enable
    logic wg_r, wg_nxt;
    logic ack_r, ack_nxt;
    logic [8:0] ma_r, ma_nxt;
    logic refDoneC;
    logic [1:0] selAge_r, selAge_nxt;    // edges the owner has stood selected

    // ----------------------------------------------------------------
    // the two helpers
    // ----------------------------------------------------------------
    dpdc_arbiter arbiter (
        .clock(clock),
        .rst(rst),
        .port1AskN(port1AskN),
        .port2AskN(port2AskN),
        .core(core.arb)
    );

    dpdc_refresh refresher (
        .clock(clock),
        .rst(rst),
        .refreshClock(refreshClock),
        .core(core.refr)
    );

    // ----------------------------------------------------------------
    // address path
    // ----------------------------------------------------------------
    // the unlatched build reads the synced pins every cycle, so the
    // processor must keep them steady for the whole access
    assign srcAddr = LATCHED ? latch_r : addrS2_r;

    // ----------------------------------------------------------------
    // sequencer next state
    // ----------------------------------------------------------------
    always_comb begin
        addrS1_nxt = hostAddrIn;
        addrS2_nxt = addrS1_r;
        latch_nxt = latch_r;
        state_nxt = state_r;
        step_nxt = step_r;
        stepInc = step_r + 4'h1;
        grant_nxt = grant_r;
        ras_nxt = ras_r;
        column_strobe_enable_n_nxt = column_strobe_enable_n_r;
        wg_nxt = wg_r;
        ack_nxt = ack_r;
        ma_nxt = ma_r;
        refDoneC = 1'b0;
        // a processor drives its address only once selected, so the grant
        // waits until that address has crossed both sync stages
        selAge_nxt = {selAge_r[0] && core.askLive, core.askLive};
        case (state_r)
            dpdc_pkg::DPDC_IDLE: begin
                step_nxt = 4'h0;
                if (core.refPending) begin
                    // refresh first, even over a selected port
                    state_nxt = dpdc_pkg::DPDC_REFRESH;
                    ma_nxt = core.refRow;
                end else if (core.askLive && selAge_r[1]) begin
                    // the select has stood long enough, now the grant
                    state_nxt = dpdc_pkg::DPDC_ACCESS;
                    grant_nxt = 1'b1;
                    latch_nxt = addrS2_r;
                    ma_nxt = addrS2_r[8:0];
                end
            end
            dpdc_pkg::DPDC_ACCESS: begin
                step_nxt = stepInc;
                // row or column half of the address
                if (stepInc >= COL_STEP) begin
                    ma_nxt = srcAddr[17:9];
                end else begin
                    ma_nxt = srcAddr[8:0];
                end
                if (stepInc == COL_STEP) begin
                    wg_nxt = 1'b1;
                end
                if (stepInc == `DPDC_T_RAS_ON) begin
                    ras_nxt = 1'b0;
                end
                if (stepInc == `DPDC_T_COLUMN_STROBE_ENABLE_N) begin
                    column_strobe_enable_n_nxt = 1'b0;
                end
                if (stepInc == `DPDC_T_RAS_OFF) begin
                    // row strobe has been low for eight half cycles
                    ras_nxt = 1'b1;
                    ack_nxt = 1'b1;
                    state_nxt = dpdc_pkg::DPDC_HOLD;
                end
            end
            dpdc_pkg::DPDC_HOLD: begin
                // everything frozen until the owner lets go
                if (!core.askLive) begin
                    state_nxt = dpdc_pkg::DPDC_IDLE;
                    grant_nxt = 1'b0;
                    column_strobe_enable_n_nxt = 1'b1;
                    wg_nxt = 1'b0;
                    ack_nxt = 1'b0;
                end
            end
            dpdc_pkg::DPDC_REFRESH: begin
                step_nxt = stepInc;
                if (stepInc == `DPDC_T_RAS_ON) begin
                    ras_nxt = 1'b0;
                end
                if (stepInc == `DPDC_T_RAS_OFF) begin
                    ras_nxt = 1'b1;
                end
                if (stepInc == `DPDC_T_REF_END) begin
                    // precharge done, advance the row counter
                    refDoneC = 1'b1;
                    state_nxt = dpdc_pkg::DPDC_IDLE;
                end
            end
            default: begin
                state_nxt = dpdc_pkg::DPDC_IDLE;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // links back to the helpers
    // ----------------------------------------------------------------
    // releasing only outside an access keeps the other port off the
    // address bus until this cycle has ended
    assign core.cycleDone = (state_r == dpdc_pkg::DPDC_HOLD) || (state_r == dpdc_pkg::DPDC_IDLE);
    assign core.refDone = refDoneC;

    // ----------------------------------------------------------------
    // sequencer registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            addrS1_r <= 18'h0;
            addrS2_r <= 18'h0;
            latch_r <= 18'h0;
            state_r <= dpdc_pkg::DPDC_IDLE;
            step_r <= 4'h0;
            grant_r <= 1'b0;
            ras_r <= 1'b1;
            column_strobe_enable_n_r <= 1'b1;
            wg_r <= 1'b0;
            ack_r <= 1'b0;
            ma_r <= 9'h0;
            selAge_r <= 2'h0;
        end else begin
            addrS1_r <= addrS1_nxt;
            addrS2_r <= addrS2_nxt;
            latch_r <= latch_nxt;
            state_r <= state_nxt;
            step_r <= step_nxt;
            grant_r <= grant_nxt;
            ras_r <= ras_nxt;
            column_strobe_enable_n_r <= column_strobe_enable_n_nxt;
            wg_r <= wg_nxt;
            ack_r <= ack_nxt;
            ma_r <= ma_nxt;
            selAge_r <= selAge_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ----------------------------------------------------------------
    assign port1ChosenN = core.chosenN[0];
    assign port2ChosenN = core.chosenN[1];
    assign cycleGrant = grant_r;
    assign transferAck = ack_r;
    assign dramAddrOut = ma_r;
    assign rowStrobeN = ras_r;
    assign columnStrobeEnableN = column_strobe_enable_n_r;
    assign writeGate = wg_r;

endmodule : dpdc_top

`default_nettype wire

// file: test/dpdc_host_model.sv
// dpdc_host_model: two processors sharing the dram behind the controller.
// assumes: go pulses are one clock wide and come from the bench.
`default_nettype none
module dpdc_host_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // bench control
    input wire logic go1,
    input wire logic go2,
    input wire logic [17:0] addr1,
    input wire logic [17:0] addr2,
    input wire logic [3:0] holdCycles,
    // controller answers
    input wire logic port1ChosenN,
    input wire logic port2ChosenN,
    input wire logic transferAck,
    // request pins and shared address bus
    output logic port1AskN,
    output logic port2AskN,
    output logic [17:0] hostAddrIn
);
    // ------
    // state
    // ------
    logic [3:0] waitCnt_r; // cycles the ack has been seen
    logic [17:0] lastAddr_r; // bus value one cycle ago
    logic doneNow; // owner may let go
    assign doneNow = transferAck && (waitCnt_r == holdCycles);
    // chosen port owns the bus; an undriven bus flips so no stale value passes
    assign hostAddrIn = !port1ChosenN ? addr1 : !port2ChosenN ? addr2 :
                        !port1AskN ? addr1 : !port2AskN ? addr2 : ~lastAddr_r;
    // requests fall on go and rise once the owner held its ack long enough
    always_ff @(posedge clock) begin
        lastAddr_r <= hostAddrIn;
        waitCnt_r <= !transferAck ? 4'h0 : (doneNow ? waitCnt_r : waitCnt_r + 4'h1);
        if (rst) begin
            port1AskN <= 1'h1;
            port2AskN <= 1'h1;
        end else begin
            if (go1) port1AskN <= 1'h0;
            else if (doneNow && !port1ChosenN) port1AskN <= 1'h1;
            if (go2) port2AskN <= 1'h0;
            else if (doneNow && !port2ChosenN) port2AskN <= 1'h1;
        end
    end
endmodule : dpdc_host_model
`default_nettype wire

// file: test/dpdc_top_asserts.sv
// dpdc_top_asserts: port timing checks for the two-port dram controller.
// assumes: bound to every dpdc_top; one clock domain.
`default_nettype none
module dpdc_top_asserts #(
    parameter bit LATCHED = 1'h1,
    parameter bit REDUCED_HOLD = 1'h0
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst,
    // processor side
    input wire logic port1AskN,
    input wire logic port2AskN,
    input wire logic [17:0] hostAddrIn,
    input wire logic port1ChosenN,
    input wire logic port2ChosenN,
    input wire logic cycleGrant,
    input wire logic transferAck,
    // refresh pacing
    input wire logic refreshClock,
    // dram side
    input wire logic [8:0] dramAddrOut,
    input wire logic rowStrobeN,
    input wire logic columnStrobeEnableN,
    input wire logic writeGate
);
    // ------
    // helpers
    // ------
    wire ownerLow = (!port1ChosenN && !port1AskN) || (!port2ChosenN && !port2AskN); // owner still asks
    default clocking cb @(posedge clock); endclocking
    sequence s_start; $rose(cycleGrant); endsequence
    sequence s_rasPulse; !rowStrobeN [*8] ##1 (rowStrobeN && transferAck); endsequence
    sequence s_refStart; $fell(rowStrobeN) && !cycleGrant; endsequence
    // ------
    // properties
    // ------
    property p_selFirst; disable iff (rst)
        s_start |-> $past(!port1ChosenN || !port2ChosenN) && (port1ChosenN != port2ChosenN); endproperty
    a_selFirst: assert property (p_selFirst) else $error("grant without one select before it");
    property p_oneSel; disable iff (rst) port1ChosenN || port2ChosenN; endproperty
    a_oneSel: assert property (p_oneSel) else $error("both ports selected");
    property p_rowStrobe; disable iff (rst) s_start |=> $fell(rowStrobeN); endproperty
    a_rowStrobe: assert property (p_rowStrobe) else $error("row strobe late after grant");
    property p_colSwitch; disable iff (rst)
        s_start |-> ##2 (writeGate == REDUCED_HOLD) ##1 writeGate; endproperty
    a_colSwitch: assert property (p_colSwitch) else $error("write gate at wrong step");
    property p_column_strobe_enable_n; disable iff (rst) s_start |-> ##4 $fell(columnStrobeEnableN); endproperty
    a_column_strobe_enable_n: assert property (p_column_strobe_enable_n) else $error("column strobe enable at wrong step");
    property p_rasWidth; disable iff (rst) s_start |=> s_rasPulse; endproperty
    a_rasWidth: assert property (p_rasWidth) else $error("row strobe width or ack wrong");
    property p_hold; disable iff (rst)
        transferAck && ownerLow |=> transferAck && cycleGrant && !columnStrobeEnableN; endproperty
    a_hold: assert property (p_hold) else $error("outputs dropped while owner asks");
    property p_release; disable iff (rst) transferAck && !ownerLow |-> ##[1:4] !transferAck; endproperty
    a_release: assert property (p_release) else $error("ack not released");
    property p_refresh; disable iff (rst) s_refStart |-> !rowStrobeN [*8] ##1 rowStrobeN [*6]; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh strobe shape wrong");
    property p_refNoGrant; disable iff (rst) s_refStart |-> !cycleGrant [*8]; endproperty
    a_refNoGrant: assert property (p_refNoGrant) else $error("grant during refresh");
    property p_reset; rst |=> port1ChosenN && port2ChosenN && !cycleGrant && !transferAck &&
        rowStrobeN && columnStrobeEnableN && !writeGate && dramAddrOut == 9'h000; endproperty
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
endmodule : dpdc_top_asserts
bind dpdc_top dpdc_top_asserts #(.LATCHED(LATCHED), .REDUCED_HOLD(REDUCED_HOLD)) u_asserts (
    .clock(clock), .rst(rst), .port1AskN(port1AskN), .port2AskN(port2AskN), .hostAddrIn(hostAddrIn),
    .port1ChosenN(port1ChosenN), .port2ChosenN(port2ChosenN), .cycleGrant(cycleGrant),
    .transferAck(transferAck), .refreshClock(refreshClock), .dramAddrOut(dramAddrOut),
    .rowStrobeN(rowStrobeN), .columnStrobeEnableN(columnStrobeEnableN), .writeGate(writeGate));
`default_nettype wire

// file: test/dual_port_dram_controller_bench.sv
// dual_port_dram_controller_bench: scenario tasks for the two-port dram controller.
// assumes: latched standard build as dut, unlatched reduced-hold build beside it.
`default_nettype none
module dual_port_dram_controller_bench;
    timeunit 1ns;
    timeprecision 100ps;
    // ------
    // signals
    // ------
    logic clock = 1'h0;
    logic rst = 1'h1;
    logic refreshClock = 1'h1; // held high: no refresh until paced
    logic go1 = 1'h0, go2 = 1'h0;
    logic [17:0] addr1 = 18'h00000, addr2 = 18'h00000;
    logic [3:0] holdCycles = 4'h0; // how long the owner keeps asking after ack
    logic port1AskN, port2AskN, port1ChosenN, port2ChosenN, cycleGrant, transferAck;
    logic rowStrobeN, columnStrobeEnableN, writeGate;
    logic [17:0] hostAddrIn;
    logic [8:0] dramAddrOut, fastAddr, rowA, rowB;
    int errTotal = 0;
    int totalChecks = 0;
    always #2.5 clock = ~clock;
    dpdc_host_model host (.clock(clock), .rst(rst), .go1(go1), .go2(go2), .addr1(addr1), .addr2(addr2),
        .holdCycles(holdCycles), .port1ChosenN(port1ChosenN), .port2ChosenN(port2ChosenN),
        .transferAck(transferAck), .port1AskN(port1AskN), .port2AskN(port2AskN), .hostAddrIn(hostAddrIn));
    dpdc_top #(.LATCHED(1'h1), .REDUCED_HOLD(1'h0)) dut (.clock(clock), .rst(rst), .port1AskN(port1AskN),
        .port2AskN(port2AskN), .hostAddrIn(hostAddrIn), .port1ChosenN(port1ChosenN),
        .port2ChosenN(port2ChosenN), .cycleGrant(cycleGrant), .transferAck(transferAck),
        .refreshClock(refreshClock), .dramAddrOut(dramAddrOut), .rowStrobeN(rowStrobeN),
        .columnStrobeEnableN(columnStrobeEnableN), .writeGate(writeGate));
    // second build follows the same requests; only its address is compared here
    dpdc_top #(.LATCHED(1'h0), .REDUCED_HOLD(1'h1)) dutAlt (.clock(clock), .rst(rst), .port1AskN(port1AskN),
        .port2AskN(port2AskN), .hostAddrIn(hostAddrIn), .port1ChosenN(), .port2ChosenN(), .cycleGrant(),
        .transferAck(), .refreshClock(refreshClock), .dramAddrOut(fastAddr), .rowStrobeN(),
        .columnStrobeEnableN(), .writeGate());
    // ------
    // shared tasks
    // ------
    task summarize;
        $display("checks %0d mismatches %0d", totalChecks, errTotal);
        if (errTotal == 0 && totalChecks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : summarize
    task check(input logic [17:0] got, input logic [17:0] exp);
        totalChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : check
    function automatic logic seen(input int kind);
        case (kind)
            0: return cycleGrant === 1'h1;
            1: return cycleGrant === 1'h0;
            2: return rowStrobeN === 1'h0 && cycleGrant === 1'h0;
            default: return port1ChosenN === 1'h1 && port2ChosenN === 1'h1;
        endcase
    endfunction : seen
    // bounded wait; a hang ends the run
    task waitOn(input int kind);
        int n;
        n = 0;
        while (!seen(kind) && n < 600) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 600) begin
            check(18'h3FFFF, kind[17:0]);
            summarize();
        end
    endtask : waitOn
    // entered just after the grant edge, while the step is still zero
    task timeline(input logic [17:0] a);
        check({9'h000, dramAddrOut}, {9'h000, a[8:0]});
        check({9'h000, fastAddr}, {9'h000, a[8:0]});
        repeat (2) @(posedge clock);
        #1;
        check({9'h000, fastAddr}, {9'h000, a[17:9]});
        @(posedge clock);
        #1;
        check({9'h000, dramAddrOut}, {9'h000, a[17:9]});
        check({17'h00000, writeGate}, 18'h00001);
        @(posedge clock);
        #1;
        check({17'h00000, columnStrobeEnableN}, 18'h00000);
        repeat (5) @(posedge clock);
        #1;
        check({16'h0000, rowStrobeN, transferAck}, 18'h00003);
    endtask : timeline
    // ------
    // scenarios
    // ------
    task testReset;
        @(posedge clock);
        #1;
        check({11'h000, port1ChosenN, port2ChosenN, cycleGrant, transferAck, rowStrobeN,
               columnStrobeEnableN, writeGate}, 18'h00066);
        repeat (40) @(posedge clock);
        #1;
        check({17'h00000, rowStrobeN}, 18'h00001);
        $display("reset test done");
    endtask : testReset
    task access(input logic port, input logic [17:0] a, input logic [3:0] hold);
        @(posedge clock);
        holdCycles <= hold;
        if (port) begin
            addr2 <= a;
            go2 <= 1'h1;
        end else begin
            addr1 <= a;
            go1 <= 1'h1;
        end
        @(posedge clock);
        go1 <= 1'h0;
        go2 <= 1'h0;
        #1;
        waitOn(0);
        check({16'h0000, port1ChosenN, port2ChosenN}, port ? 18'h00002 : 18'h00001);
        timeline(a);
        waitOn(3);
        check({15'h0000, cycleGrant, transferAck, columnStrobeEnableN}, 18'h00001);
        $display("access test done");
    endtask : access
    task testContention;
        @(posedge clock);
        addr1 <= 18'h3F0A1;
        addr2 <= 18'h05E3C;
        go1 <= 1'h1;
        @(posedge clock);
        go1 <= 1'h0;
        go2 <= 1'h1;
        @(posedge clock);
        go2 <= 1'h0;
        #1;
        waitOn(0);
        check({16'h0000, port1ChosenN, port2ChosenN}, 18'h00001);
        timeline(18'h3F0A1);
        waitOn(1);
        waitOn(0);
        check({16'h0000, port1ChosenN, port2ChosenN}, 18'h00002);
        timeline(18'h05E3C);
        waitOn(3);
        $display("contention test done");
    endtask : testContention
    task testRefresh(output logic [8:0] row);
        repeat (64) begin
            repeat (2) @(posedge clock);
            refreshClock <= 1'h0;
            repeat (2) @(posedge clock);
            refreshClock <= 1'h1;
        end
        #1;
        waitOn(2);
        row = dramAddrOut;
        @(posedge clock);
        addr1 <= 18'h2A5C3;
        go1 <= 1'h1;
        @(posedge clock);
        go1 <= 1'h0;
        repeat (5) @(posedge clock);
        #1;
        check({16'h0000, port1ChosenN, cycleGrant}, 18'h00000);
        waitOn(0);
        timeline(18'h2A5C3);
        waitOn(3);
        $display("refresh test done");
    endtask : testRefresh
    // ------
    // main sequence
    // ------
    initial begin
        repeat (5) @(posedge clock);
        rst <= 1'h0;
        testReset();
        access(1'h0, 18'h1B2D4, 4'h0);
        access(1'h1, 18'h2C6E9, 4'h5);
        testContention();
        testRefresh(rowA);
        testRefresh(rowB);
        check({9'h000, rowB}, {9'h000, rowA + 9'h001});
        summarize();
    end
endmodule : dual_port_dram_controller_bench
`default_nettype wire
